// [lpw_gs_if.sv]
// Interface between the tracking top and the grayscale PWM core
`default_nettype none

interface lpw_gs_if;
  logic gs_tick;
  logic latch_pulse;
  logic auto_repeat;
  logic [lpw_pkg::CH_N*lpw_pkg::GS_W-1:0] codes;
  logic [lpw_pkg::CH_N-1:0] sink_on;
  logic [lpw_pkg::GS_W-1:0] gs_count;
  logic running;
  logic cycle_end;

  modport core (
    input gs_tick, latch_pulse, auto_repeat, codes,
    output sink_on, gs_count, running, cycle_end
  );

  modport ctl (
    output gs_tick, latch_pulse, auto_repeat, codes,
    input sink_on, gs_count, running, cycle_end
  );
endinterface : lpw_gs_if

`default_nettype wire

// [lpw_load_model.sv]
// Behavioural LED strings and buck stage feeding the sink comparators
`default_nettype none

module lpw_load_model (
  input wire logic [lpw_pkg::CH_N-1:0] led_sink_output,
  input wire logic [7:0] vmin_dv,
  input wire logic [7:0] spread_dv,
  output logic sink_min_below_low,
  output logic sink_min_above_high,
  output logic sink_max_over_limit
);
  timeunit 1ns;
  timeprecision 100ps;

  logic all_on;
  logic [8:0] vmax_dv;

  ////////////////////////////////////////////////////////////////////////////
  // Voltages are in tenths of a volt, set by the bench per scenario.
  // Sinks that are off float up to the anode, so they read high and over;
  // the block must only trust the flags with every sink on.
  always_comb begin
    all_on = &led_sink_output;
    vmax_dv = {1'b0, vmin_dv} + {1'b0, spread_dv};
    sink_min_below_low = all_on && (vmin_dv < 8'h09);
    sink_min_above_high = !all_on || (vmin_dv > 8'h0B);
    sink_max_over_limit = !all_on || (vmax_dv > 9'h028);
  end
endmodule : lpw_load_model

`default_nettype wire

// [lpw_pkg.sv]
// Shared constants, state encoding and receiver decode for the LED PWM block
`default_nettype none

package lpw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int GS_STEP_NS = 200;
  // Least time, rounded up to whole cycles
  localparam int GS_STEP_CYC =
    (GS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DRV_EN_MS = 1000;
  localparam int DRV_EN_CYC = DRV_EN_MS * (1000000 / CLK_PERIOD_NS);
  localparam int SOFT_START_MS = 800;
  // Longest time, rounded down
  localparam int SOFT_START_CYC = SOFT_START_MS * (1000000 / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Grayscale and tracking fields
  localparam int CH_N = 3;
  localparam int GS_W = 12;
  localparam logic [11:0] GS_CNT_RESET = 12'h000;
  localparam logic [11:0] GS_FIRST = 12'h001;
  localparam logic [11:0] GS_LAST = 12'hFFF;
  localparam logic [11:0] GS_OFF = 12'h000;
  localparam logic [11:0] SAMPLE_EDGE = 12'h020;
  localparam logic [11:0] STEP_EDGE = 12'h021;
  localparam int TGT_W = 6;
  localparam logic [5:0] TGT_RESET = 6'h00;
  localparam logic [5:0] TGT_MIN = 6'h00;
  localparam logic [5:0] TGT_MAX = 6'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // PWM sequencer states
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_armed = 3'b010,
    st_run = 3'b100
  } lpw_pwm_state_t;

  // Receiver level: open reads low, the dead band keeps the last level
  function automatic logic rx_level(input logic hi, input logic lo,
                                    input logic open, input logic prev);
    logic lvl;
    lvl = prev;
    if (open) begin
      lvl = 1'b0;
    end else if (hi) begin
      lvl = 1'b1;
    end else if (lo) begin
      lvl = 1'b0;
    end
    return lvl;
  endfunction : rx_level

endpackage : lpw_pkg

`default_nettype wire

// [lpw_pwm_core.sv]
// Grayscale counter, repeat sequencing and per-channel on/off compare
`default_nettype none

module lpw_pwm_core (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  lpw_gs_if.core gs
);

  lpw_pkg::lpw_pwm_state_t state;
  logic [11:0] cnt;
  logic end_tick;

  // All checks share the one clock and stay quiet during reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  assign end_tick = (state == lpw_pkg::st_run) && gs.gs_tick &&
                    (cnt == lpw_pkg::GS_LAST);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= lpw_pkg::st_idle;
      cnt <= lpw_pkg::GS_CNT_RESET;
    end else if (clk_en) begin
      case (state)
        lpw_pkg::st_idle: begin
          if (gs.latch_pulse) begin
            state <= lpw_pkg::st_armed;
          end
        end
        lpw_pkg::st_armed: begin
          // A latch in the same cycle waits for a following clock edge
          if (gs.gs_tick && !gs.latch_pulse) begin
            state <= lpw_pkg::st_run;
            cnt <= lpw_pkg::GS_FIRST;
          end
        end
        lpw_pkg::st_run: begin
          if (gs.latch_pulse) begin
            state <= lpw_pkg::st_armed;
            cnt <= lpw_pkg::GS_CNT_RESET;
          end else if (end_tick) begin
            state <= gs.auto_repeat ? lpw_pkg::st_armed : lpw_pkg::st_idle;
            cnt <= lpw_pkg::GS_CNT_RESET;
          end else if (gs.gs_tick) begin
            cnt <= cnt + 12'h001;
          end
        end
        default: begin
          state <= lpw_pkg::st_idle;
          cnt <= lpw_pkg::GS_CNT_RESET;
        end
      endcase
    end
  end

  assign gs.gs_count = cnt;
  assign gs.running = (state == lpw_pkg::st_run);
  assign gs.cycle_end = end_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Channel compare: on while the count has not passed the code
  for (genvar i = 0; i < lpw_pkg::CH_N; i++) begin : g_ch
    logic [11:0] code;
    assign code = gs.codes[i*lpw_pkg::GS_W +: lpw_pkg::GS_W];
    assign gs.sink_on[i] = (state == lpw_pkg::st_run) &&
                           (code != lpw_pkg::GS_OFF) && (cnt <= code);

    sink_off_a: assert property (
      ((cnt > code) || (code == lpw_pkg::GS_OFF)) |-> !gs.sink_on[i])
      else $error("channel on past its code");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  repeat_rearm_a: assert property (
    (end_tick && clk_en && gs.auto_repeat && !gs.latch_pulse) |=>
    (state == lpw_pkg::st_armed))
    else $error("auto repeat did not re-arm");

  restart_first_a: assert property (
    ((state == lpw_pkg::st_armed) && gs.gs_tick && !gs.latch_pulse && clk_en)
    |=> (state == lpw_pkg::st_run) && (cnt == lpw_pkg::GS_FIRST))
    else $error("armed cycle did not start on clock edge");

  no_repeat_a: assert property (
    (end_tick && clk_en && !gs.auto_repeat && !gs.latch_pulse) |=>
    (state == lpw_pkg::st_idle) && !gs.running)
    else $error("display restarted without latch");

endmodule : lpw_pwm_core

`default_nettype wire

// [lpw_top.sv]
// LED PWM sequencer with anode tracking and differential repeater
// Behaviour
// - With auto repeat set, a finished cycle restarts on the next clock.
// - With auto repeat clear, outputs stay off until latch then clock.
// - Codes are 12 bits; 000 off, FFF full; one step is 200 ns.
// - Repeater drivers stay disabled until one second after power-up.
// - Receiver reads high above +0.2 V, low below -0.2 V; open is low.
// - Positive output follows internal level, negative output is inverted.
// - A soft-start ramp to the stored target finishes within 800 ms.
// - Lowest sink below 0.9 V at clock 32 raises target at 33.
// - Lowest sink above 1.1 V lowers target by exactly one step.
// - Lowest sink between the limits leaves the target unchanged.
// - Highest sink above 4.0 V at clock 32 blocks any rise.
// - Counter counts clock edges; output turns off once count passes code.
// - Source select clear uses oscillator, set uses received shift clock.
// - Oscillator step is two oscillator periods; external step one period.
`default_nettype none

module lpw_top #(
  parameter int DRV_EN_CYC = lpw_pkg::DRV_EN_CYC,
  parameter int SOFT_START_CYC = lpw_pkg::SOFT_START_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic auto_display_repeat,
  input wire logic gs_clock_ext_sel,
  input wire logic latch_pulse,
  input wire logic [lpw_pkg::CH_N*lpw_pkg::GS_W-1:0] channel_brightness_code,
  input wire logic [lpw_pkg::TGT_W-1:0] anode_feedback_target,
  input wire logic data_in_hi,
  input wire logic data_in_lo,
  input wire logic data_in_open,
  input wire logic clock_in_hi,
  input wire logic clock_in_lo,
  input wire logic clock_in_open,
  input wire logic sink_min_below_low,
  input wire logic sink_min_above_high,
  input wire logic sink_max_over_limit,
  output logic [lpw_pkg::CH_N-1:0] led_sink_output,
  output logic grayscale_step_clock,
  output logic rx_data,
  output logic rx_clock,
  output logic data_out_pos,
  output logic data_out_neg,
  output logic clock_out_pos,
  output logic clock_out_neg,
  output logic repeater_oe_n,
  output logic [lpw_pkg::TGT_W-1:0] anode_target_step,
  output logic soft_start_done
);

  // Positions of the pin inputs in the synchroniser
  localparam int I_DHI = 0;
  localparam int I_DLO = 1;
  localparam int I_DOPEN = 2;
  localparam int I_CHI = 3;
  localparam int I_CLO = 4;
  localparam int I_COPEN = 5;
  localparam int I_LOW = 6;
  localparam int I_HIGH = 7;
  localparam int I_OVP = 8;
  localparam int SYNC_N = 9;
  localparam int RAMP_DIV = SOFT_START_CYC / (2 ** lpw_pkg::TGT_W);
  localparam int RAMP_CYC = (RAMP_DIV < 1) ? 1 : RAMP_DIV;

  lpw_gs_if gs ();

  logic [SYNC_N-1:0] pin_async;
  logic [SYNC_N-1:0] sync_a;
  logic [SYNC_N-1:0] sync_b;
  logic rx_clock_q;
  logic ext_rise;
  logic [7:0] osc_cnt;
  logic osc_tick;
  logic gs_tick;
  logic [31:0] drv_cnt;
  logic drv_en;
  logic [31:0] ramp_cnt;
  logic [31:0] soft_elapsed;
  logic edge32;
  logic edge33;
  logic all_on;
  logic flag_low;
  logic flag_high;
  logic flag_ovp;
  logic flag_valid;
  logic step_now;
  logic [lpw_pkg::TGT_W-1:0] next_tgt;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read
  assign pin_async = {sink_max_over_limit, sink_min_above_high,
                      sink_min_below_low, clock_in_open, clock_in_lo,
                      clock_in_hi, data_in_open, data_in_lo, data_in_hi};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync_a <= '0;
      sync_b <= '0;
    end else if (clk_en) begin
      sync_a <= pin_async;
      sync_b <= sync_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver decode
  // threshold decode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_data <= 1'b0;
      rx_clock <= 1'b0;
      rx_clock_q <= 1'b0;
    end else if (clk_en) begin
      rx_data <= lpw_pkg::rx_level(sync_b[I_DHI], sync_b[I_DLO],
                                   sync_b[I_DOPEN], rx_data);
      rx_clock <= lpw_pkg::rx_level(sync_b[I_CHI], sync_b[I_CLO],
                                    sync_b[I_COPEN], rx_clock);
      rx_clock_q <= rx_clock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Grayscale clock source
  // Shift clock edges are seen after sync, so it must stay well below ref_clk
  assign ext_rise = rx_clock && !rx_clock_q;
  assign osc_tick = (osc_cnt == 8'(lpw_pkg::GS_STEP_CYC - 1));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      osc_cnt <= 8'h00;
    end else if (clk_en) begin
      osc_cnt <= osc_tick ? 8'h00 : osc_cnt + 8'h01;
    end
  end

  assign gs_tick = clk_en && (gs_clock_ext_sel ? ext_rise : osc_tick);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      grayscale_step_clock <= 1'b0;
    end else if (clk_en) begin
      grayscale_step_clock <= gs_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM core
  assign gs.gs_tick = gs_tick;
  assign gs.latch_pulse = latch_pulse;
  assign gs.auto_repeat = auto_display_repeat;
  assign gs.codes = channel_brightness_code;

  lpw_pwm_core u_core (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .gs(gs.core)
  );

  // Sink outputs registered for clean edges
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      led_sink_output <= '0;
    end else if (clk_en) begin
      led_sink_output <= gs.sink_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Repeater driver enable and outputs
  // power-up hold-off
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      drv_cnt <= 32'h0000_0000;
      drv_en <= 1'b0;
    end else if (clk_en && !drv_en) begin
      if (drv_cnt == 32'(DRV_EN_CYC - 1)) begin
        drv_en <= 1'b1;
      end else begin
        drv_cnt <= drv_cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      repeater_oe_n <= 1'b1;
      data_out_pos <= 1'b0;
      data_out_neg <= 1'b0;
      clock_out_pos <= 1'b0;
      clock_out_neg <= 1'b0;
    end else if (clk_en) begin
      repeater_oe_n <= !drv_en;
      data_out_pos <= drv_en && rx_data;
      data_out_neg <= drv_en && !rx_data;
      clock_out_pos <= drv_en && rx_clock;
      clock_out_neg <= drv_en && !rx_clock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator sampling at the 32nd edge, step at the 33rd
  localparam logic [11:0] SAMPLE_PREV = lpw_pkg::SAMPLE_EDGE - 12'h001;
  localparam logic [11:0] STEP_PREV = lpw_pkg::STEP_EDGE - 12'h001;
  assign edge32 = gs_tick && gs.running && (gs.gs_count == SAMPLE_PREV);
  assign edge33 = gs_tick && gs.running && (gs.gs_count == STEP_PREV);

  // Every channel must still be on at the sample edge
  always_comb begin
    all_on = 1'b1;
    for (int i = 0; i < lpw_pkg::CH_N; i++) begin
      if (channel_brightness_code[i*lpw_pkg::GS_W +: lpw_pkg::GS_W] <
          lpw_pkg::SAMPLE_EDGE) begin
        all_on = 1'b0;
      end
    end
  end

  // flags taken at the sample edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flag_low <= 1'b0;
      flag_high <= 1'b0;
      flag_ovp <= 1'b0;
      flag_valid <= 1'b0;
    end else if (clk_en) begin
      if (edge32) begin
        flag_low <= sync_b[I_LOW];
        flag_high <= sync_b[I_HIGH];
        flag_ovp <= sync_b[I_OVP];
        flag_valid <= all_on;
      end else if (edge33) begin
        flag_valid <= 1'b0;
      end
    end
  end

  assign step_now = edge33 && flag_valid && soft_start_done;

  // Low wins over high if both are flagged, so a starved LED is fed first
  always_comb begin
    next_tgt = anode_target_step;
    if (flag_low && !flag_ovp && (anode_target_step != lpw_pkg::TGT_MAX)) begin
      next_tgt = anode_target_step + 6'h01;
    end else if (flag_high && !flag_low &&
                 (anode_target_step != lpw_pkg::TGT_MIN)) begin
      next_tgt = anode_target_step - 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft start ramp then tracking
  // bounded ramp to stored target
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      anode_target_step <= lpw_pkg::TGT_RESET;
      soft_start_done <= 1'b0;
      ramp_cnt <= 32'h0000_0000;
      soft_elapsed <= 32'h0000_0000;
    end else if (clk_en) begin
      if (!soft_start_done) begin
        soft_elapsed <= soft_elapsed + 32'h0000_0001;
        if ((anode_target_step >= anode_feedback_target) ||
            (soft_elapsed == 32'(SOFT_START_CYC - 1))) begin
          anode_target_step <= anode_feedback_target;
          soft_start_done <= 1'b1;
        end else if (ramp_cnt == 32'(RAMP_CYC - 1)) begin
          ramp_cnt <= 32'h0000_0000;
          anode_target_step <= anode_target_step + 6'h01;
        end else begin
          ramp_cnt <= ramp_cnt + 32'h0000_0001;
        end
      end else if (step_now) begin
        anode_target_step <= next_tgt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_clk_rise;
    clk_en && !rx_clock ##1 clk_en && rx_clock && gs_clock_ext_sel;
  endsequence

  sequence s_osc_step;
    !gs_clock_ext_sel && gs_tick ##1 clk_en && !gs_clock_ext_sel;
  endsequence

  ext_source_a: assert property (
    s_clk_rise |-> gs_tick)
    else $error("shift clock edge not used as step");
  osc_step_a: assert property (
    s_osc_step |-> !gs_tick)
    else $error("oscillator step shorter than two periods");
  drv_hold_a: assert property (
    (drv_cnt < 32'(DRV_EN_CYC - 1)) |-> !drv_en && repeater_oe_n)
    else $error("repeater enabled before hold-off");
  drv_open_a: assert property (
    (drv_en && clk_en) |=> !repeater_oe_n)
    else $error("repeater not enabled after hold-off");
  rx_open_a: assert property (
    (clk_en && sync_b[I_DOPEN]) |=> !rx_data)
    else $error("open input not read as low");
  rx_high_a: assert property (
    (clk_en && sync_b[I_DHI] && !sync_b[I_DOPEN]) |=> rx_data)
    else $error("high input not read as high");
  drv_polarity_a: assert property (
    (clk_en && drv_en) |=> (data_out_pos == $past(rx_data)) &&
    (data_out_neg != data_out_pos) && (clock_out_neg != clock_out_pos))
    else $error("driver polarity wrong");
  soft_bound_a: assert property (
    !soft_start_done |-> soft_elapsed < 32'(SOFT_START_CYC))
    else $error("soft start too long");
  step_up_a: assert property (
    (clk_en && step_now && flag_low && !flag_ovp &&
     anode_target_step != lpw_pkg::TGT_MAX) |=>
    anode_target_step == $past(anode_target_step) + 6'h01)
    else $error("target not raised");
  step_down_a: assert property (
    (clk_en && step_now && flag_high && !flag_low &&
     anode_target_step != lpw_pkg::TGT_MIN) |=>
    anode_target_step == $past(anode_target_step) - 6'h01)
    else $error("target not lowered by one");
  step_hold_a: assert property (
    (clk_en && step_now && !flag_low && !flag_high) |=>
    $stable(anode_target_step))
    else $error("target moved inside band");
  ovp_block_a: assert property (
    (clk_en && step_now && flag_ovp) |=>
    anode_target_step <= $past(anode_target_step))
    else $error("target raised during overvoltage");
  step_sat_a: assert property (
    (step_now && anode_target_step == lpw_pkg::TGT_MAX) |=>
    anode_target_step != lpw_pkg::TGT_MIN)
    else $error("target wrapped");
  flag_take_a: assert property (
    (clk_en && edge32) |=> (flag_low == $past(sync_b[I_LOW])) &&
    (flag_ovp == $past(sync_b[I_OVP])))
    else $error("flags not taken at sample edge");

endmodule : lpw_top

`default_nettype wire

// [testbench.sv]
// Self-checking bench for the LED PWM, repeater and anode tracking top
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int DRV_CYC = 50;
  localparam int SS_CYC = 640;
  localparam int STEP = 2; // Clock cycles per internal grayscale step
  localparam int FRAME = 4096 * STEP;

  logic ref_clk;
  logic reset;
  logic clk_en;
  logic auto_display_repeat;
  logic gs_clock_ext_sel;
  logic latch_pulse;
  logic [lpw_pkg::CH_N*lpw_pkg::GS_W-1:0] channel_brightness_code;
  logic [lpw_pkg::TGT_W-1:0] anode_feedback_target;
  logic data_in_hi, data_in_lo, data_in_open;
  logic clock_in_hi, clock_in_lo, clock_in_open;
  logic below, above, over;
  logic [7:0] vmin_dv;
  logic [7:0] spread_dv;
  logic [lpw_pkg::CH_N-1:0] led_sink_output;
  logic grayscale_step_clock;
  logic rx_data, rx_clock, repeater_oe_n, soft_start_done;
  logic data_out_pos, data_out_neg, clock_out_pos, clock_out_neg;
  logic [lpw_pkg::TGT_W-1:0] anode_target_step;
  logic [5:0] stp;
  int num_errors;
  int cmp_count;
  int on_cnt [3];
  int tick_cnt;

  lpw_top #(.DRV_EN_CYC(DRV_CYC), .SOFT_START_CYC(SS_CYC)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .auto_display_repeat(auto_display_repeat),
    .gs_clock_ext_sel(gs_clock_ext_sel), .latch_pulse(latch_pulse),
    .channel_brightness_code(channel_brightness_code),
    .anode_feedback_target(anode_feedback_target),
    .data_in_hi(data_in_hi), .data_in_lo(data_in_lo),
    .data_in_open(data_in_open), .clock_in_hi(clock_in_hi),
    .clock_in_lo(clock_in_lo), .clock_in_open(clock_in_open),
    .sink_min_below_low(below), .sink_min_above_high(above),
    .sink_max_over_limit(over), .led_sink_output(led_sink_output),
    .grayscale_step_clock(grayscale_step_clock),
    .rx_data(rx_data), .rx_clock(rx_clock),
    .data_out_pos(data_out_pos), .data_out_neg(data_out_neg),
    .clock_out_pos(clock_out_pos), .clock_out_neg(clock_out_neg),
    .repeater_oe_n(repeater_oe_n), .anode_target_step(anode_target_step),
    .soft_start_done(soft_start_done));

  lpw_load_model u_load (
    .led_sink_output(led_sink_output), .vmin_dv(vmin_dv),
    .spread_dv(spread_dv), .sink_min_below_low(below),
    .sink_min_above_high(above), .sink_max_over_limit(over));

  // Clock at 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", name, expv, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic do_reset(input logic [5:0] tgt);
    @(posedge ref_clk);
    reset <= 1'b1;
    anode_feedback_target <= tgt;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
  endtask : do_reset

  task automatic pulse_latch();
    @(posedge ref_clk);
    latch_pulse <= 1'b1;
    @(posedge ref_clk);
    latch_pulse <= 1'b0;
  endtask : pulse_latch

  // Counts sink on-cycles per channel and step pulses, sampled mid-cycle
  task automatic measure(input int n);
    on_cnt = '{0, 0, 0};
    tick_cnt = 0;
    repeat (n) begin
      @(negedge ref_clk);
      for (int i = 0; i < 3; i++) begin
        if (led_sink_output[i] === 1'b1) begin
          on_cnt[i]++;
        end
      end
      if (grayscale_step_clock === 1'b1) begin
        tick_cnt++;
      end
    end
  endtask : measure

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle

  // Latch restarts the frame; the window ends before a second sample
  task automatic track(input logic [7:0] vmin, input logic [7:0] spr,
                       output logic [5:0] seen);
    @(posedge ref_clk);
    vmin_dv <= vmin;
    spread_dv <= spr;
    pulse_latch();
    settle(50 * STEP);
    seen = anode_target_step;
  endtask : track

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_repeater();
    @(posedge ref_clk);
    data_in_hi <= 1'b1;
    settle(DRV_CYC - 10);
    check("oe_n early", repeater_oe_n, 1);
    check("pos early", data_out_pos, 0);
    check("rx high", rx_data, 1);
    // Frozen cycles must not advance the power-up hold-off
    @(posedge ref_clk);
    clk_en <= 1'b0;
    settle(15);
    check("oe_n frozen", repeater_oe_n, 1);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    settle(20);
    check("oe_n late", repeater_oe_n, 0);
    check("pos high", data_out_pos, 1);
    check("neg high", data_out_neg, 0);
    check("clk pair", {clock_out_pos, clock_out_neg}, 2'b01);
    @(posedge ref_clk);
    data_in_hi <= 1'b0;
    data_in_lo <= 1'b1;
    settle(5);
    check("rx low", rx_data, 0);
    check("pos low", {data_out_pos, data_out_neg}, 2'b01);
    @(posedge ref_clk);
    data_in_lo <= 1'b0;
    data_in_hi <= 1'b1;
    data_in_open <= 1'b1;
    settle(5);
    check("rx open", rx_data, 0);
    @(posedge ref_clk);
    data_in_open <= 1'b0;
    data_in_hi <= 1'b0;
  endtask : t_repeater

  task automatic t_soft_start(input logic [5:0] tgt);
    int n;
    n = 0;
    while (soft_start_done !== 1'b1 && n < SS_CYC) begin
      @(negedge ref_clk);
      n++;
    end
    check("ss done", soft_start_done, 1);
    check("ss target", anode_target_step, tgt);
  endtask : t_soft_start

  task automatic t_single_frame();
    @(posedge ref_clk);
    channel_brightness_code <= {12'hFFF, 12'h003, 12'h000};
    pulse_latch();
    measure(FRAME + 200);
    check("code 000", on_cnt[0], 0);
    check("code 003", on_cnt[1], 3 * STEP);
    check("code FFF", on_cnt[2], 4095 * STEP);
    measure(FRAME);
    check("idle sum", on_cnt[0] + on_cnt[1] + on_cnt[2], 0);
  endtask : t_single_frame

  task automatic t_repeat();
    @(posedge ref_clk);
    auto_display_repeat <= 1'b1;
    pulse_latch();
    measure(FRAME + 100);
    check("repeat", on_cnt[1], 6 * STEP);
    @(posedge ref_clk);
    auto_display_repeat <= 1'b0;
  endtask : t_repeat

  // Shift clock period of 8 cycles drives the steps
  task automatic t_ext_clock();
    @(posedge ref_clk);
    gs_clock_ext_sel <= 1'b1;
    pulse_latch();
    fork
      measure(100);
      repeat (12) begin
        clock_in_hi <= 1'b1;
        clock_in_lo <= 1'b0;
        repeat (4) @(posedge ref_clk);
        clock_in_hi <= 1'b0;
        clock_in_lo <= 1'b1;
        repeat (4) @(posedge ref_clk);
      end
    join
    check("ext step", on_cnt[1], 3 * 8);
    check("ext off", on_cnt[0], 0);
    check("ext ticks", tick_cnt, 12);
    check("rx clock low", rx_clock, 0);
    @(posedge ref_clk);
    gs_clock_ext_sel <= 1'b0;
  endtask : t_ext_clock

  task automatic t_tracking();
    @(posedge ref_clk);
    channel_brightness_code <= {12'h040, 12'h040, 12'h040};
    track(8'h05, 8'h0A, stp);
    check("up", stp, 6'h06);
    track(8'h05, 8'h28, stp);
    check("up blocked", stp, 6'h06);
    track(8'h0F, 8'h0A, stp);
    check("down", stp, 6'h05);
    track(8'h0A, 8'h0A, stp);
    check("hold", stp, 6'h05);
  endtask : t_tracking

  task automatic t_saturate();
    do_reset(6'h00);
    settle(2);
    check("oe_n reset", repeater_oe_n, 1);
    t_soft_start(6'h00);
    track(8'h0F, 8'h0A, stp);
    check("floor", stp, 6'h00);
    // Full-scale ramp, then a rise request must hold at the top
    do_reset(6'h3F);
    t_soft_start(6'h3F);
    track(8'h05, 8'h0A, stp);
    check("ceiling", stp, 6'h3F);
  endtask : t_saturate

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    auto_display_repeat = 1'b0;
    gs_clock_ext_sel = 1'b0;
    latch_pulse = 1'b0;
    channel_brightness_code = '0;
    anode_feedback_target = 6'h05;
    {data_in_hi, data_in_lo, data_in_open} = 3'b000;
    {clock_in_hi, clock_in_lo, clock_in_open} = 3'b000;
    vmin_dv = 8'h0A;
    spread_dv = 8'h0A;
    num_errors = 0;
    cmp_count = 0;
    do_reset(6'h05);
    t_repeater();
    t_soft_start(6'h05);
    t_single_frame();
    t_repeat();
    t_ext_clock();
    t_tracking();
    t_saturate();
    stop_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end
endmodule : testbench

`default_nettype wire
